// >>> pkg/seq_ext_pkg.sv
// Constants and carrier types for the sequencer extension register bank.
// Assumes one system clock and an index/data I/O port pair from the host.
package seq_ext_pkg;

    // ------------------------------------------------------------------
    // Register indices and write masks
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_ICON3 = 8'h2D;
    localparam logic [7:0] IDX_CURSOR = 8'h2E;
    localparam logic [7:0] IDX_HFA_PROG = 8'h2F;
    localparam logic [7:0] IDX_VW_DAC = 8'h32;
    localparam logic [7:0] IDX_SPARE = 8'h33;
    localparam logic [7:0] IDX_HOST_STOP = 8'h34;
    localparam logic [7:0] MASK_ICON3 = 8'hFF;
    localparam logic [7:0] MASK_CURSOR = 8'h07;
    localparam logic [7:0] MASK_HFA_PROG = 8'hFF;
    localparam logic [7:0] MASK_VW_DAC = 8'h27;
    localparam logic [7:0] MASK_HOST_STOP = 8'h1F;
    localparam logic [7:0] RST_VAL = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int B_I3_EN = 0;
    localparam int B_I3_MODE = 1;
    localparam int B_I3_BLINK = 2;
    localparam int B_I3_HDBL = 3;
    localparam int B_I3_VDBL = 4;
    localparam int B_I3_MAP = 5;
    localparam int B_NARROW = 6;
    localparam int B_WIDE = 7;
    localparam int B_FINE3 = 0;
    localparam int B_EXTMAP = 1;
    localparam int B_THR = 0;
    localparam int B_PCLK_DIS = 4;
    localparam int B_PROG = 5;
    localparam int B_VWCAS = 0;
    localparam int B_DAC_CURRENT_REFERENCE = 5;
    localparam int B_STOP = 0;
    localparam int PROG_TVON = 0;
    localparam int PROG_NTSC = 2;

    // ------------------------------------------------------------------
    // Half-frame read FIFO geometry
    // ------------------------------------------------------------------
    localparam logic [4:0] HFA_STAGES = 5'h10;
    localparam logic [4:0] HFA_FILL_STEP = 5'h02;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic data_sel;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic linear_addr;
        logic ext_mode;
        logic graphics_mode;
        logic horiz_expand;
        logic cursor_icon_sel;
        logic icon0_map_sel;
        logic tv_out_sel;
        logic ntsc_pal;
        logic tv_power_on_output;
        logic pclk_sel;
        logic flat_panel_en;
        logic text_blink;
        logic [7:0] coarse_hpos;
        logic [2:0] fine_hpos_low;
    } ctx_t;

    typedef struct packed {
        logic icon_host_64;
        logic icon_fetch_64;
        logic icon3_visible;
        logic icon3_map_sel;
        logic icon3_vdouble;
        logic icon3_hdouble;
        logic icons_pushed_down;
        logic icon3_transparent;
        logic icons_1_3_allowed;
        logic [2:0] icon0_map_index;
        logic [11:0] cursor_hpos;
        logic [2:0] prog_pins;
        logic pclk_out_en;
        logic dac_dac_current_reference_on;
        logic [2:0] hfa_vw_cas;
        logic [4:0] host_stop;
    } status_t;

endpackage

// >>> hw/hfa_fifo_tracker.sv
// Empty-stage tracker for the half-frame read FIFO.
// Assumes drain and fill strobes are one-cycle pulses on the system clock.
`timescale 1ns/100ps
module hfa_fifo_tracker (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Threshold and FIFO events.
    input wire logic [3:0] thr_i,
    input wire logic drain_i,
    input wire logic fill_i,
    // Request and level.
    output logic fill_req_o,
    output logic [4:0] empty_o
);
    import seq_ext_pkg::*;

    logic [4:0] empty_q; // Empty 32-bit stages, FIFO starts empty.
    logic [4:0] empty_d;
    logic req_q; // Registered fill request.
    logic [4:0] up; // Stage freed by a 32-bit drain.
    logic [4:0] dn; // Two stages taken by a 64-bit fill.

    // ------------------------------------------------------------------
    // Level arithmetic
    // ------------------------------------------------------------------
    // Drain and fill may coincide; the FIFO keeps refilling while it drains.
    assign up = (drain_i && empty_q != HFA_STAGES) ? 5'h01 : 5'h00; // [RULE_19]
    assign dn = (fill_i && empty_q >= HFA_FILL_STEP) ? HFA_FILL_STEP : 5'h00;
    assign empty_d = empty_q + up - dn;

    // Level and request registers.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            empty_q <= HFA_STAGES;
            req_q <= 1'b0;
        end else begin
            empty_q <= empty_d;
            req_q <= (empty_d >= {1'b0, thr_i}); // [RULE_19]
        end
    end

    assign fill_req_o = req_q;
    assign empty_o = empty_q;

    // Request follows the empty count against the threshold; the first edge after
    // reset is skipped because the request flop only then takes its first value.
    fill_req_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [RULE_19]
        (empty_q >= {1'b0, thr_i}) && $stable(thr_i) && $past(rst_n_i) |-> fill_req_o)
        else $error("Fill request missing at threshold.");
endmodule

// >>> hw/icon_cursor_hfa_seq_regs.sv
// Sequencer extension register bank: icon 3, cursor fine position,
// programmable pins, pixel clock gating, half-frame FIFO thresholds.
// Assumes the host drives index/data port strobes on the system clock
// and that all mode context comes from logic on the same clock.
//
// What this block does
// RULE_01: Linear addressing limits host to 32-bit unless wide.
// RULE_02: Software sets narrow-read when clearing wide access.
// RULE_03: Narrow-read clear forces 64-bit icon fetch.
// RULE_04: Icon 3 map bit picks map 0 or 1.
// RULE_05: Vertical doubling gives 128 lines, pushes icons down.
// RULE_06: Horizontal doubling gives 128 pixel wide icon.
// RULE_07: Blink toggles icon at half cursor rate.
// RULE_08: Mode bit picks four colours or transparent.
// RULE_09: Icon 3 shown only while enable set.
// RULE_10: Non-zero extended map disables icons one to three.
// RULE_11: Extended field plus map bit index eight maps.
// RULE_12: Cursor position joins coarse, fine bit, low bits.
// RULE_13: Fine bit writes only when cursor selected.
// RULE_14: Non-expanded graphics forces fine bit to zero.
// RULE_15: Software places cursor within ten dots first.
// RULE_16: Pin bits drive pins while TV select clear.
// RULE_17: TV select routes standard and power to pins.
// RULE_18: Disable bit gates pixel clock to panel use.
// RULE_19: Fill request once empty stages reach threshold.
// RULE_20: Software keeps half-frame threshold between four and fifteen.
// RULE_21: DAC reference power follows its bit.
// RULE_22: Video window fill uses field-count column strobes.
// RULE_23: Reserved bits read zero, ignore writes.
`timescale 1ns/100ps
module icon_cursor_hfa_seq_regs (
    // Clock and reset.
    input wire logic CLK_SYS_I,
    input wire logic RESETN_I,
    // Host index/data port.
    input wire seq_ext_pkg::io_req_t IO_REQ_I,
    output logic [7:0] IO_RDATA_O,
    // Display mode context.
    input wire seq_ext_pkg::ctx_t CTX_I,
    // Half-frame FIFO events.
    input wire logic HFA_DRAIN_I,
    input wire logic HFA_FILL_I,
    // Block outputs.
    output seq_ext_pkg::status_t STATUS_O,
    output logic HFA_FILL_REQ_O
);
    import seq_ext_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] index_q; // Current register index.
    logic [7:0] icon3_q; // Icon 3 control and memory access.
    logic [7:0] cursor_q; // Cursor fine bit and icon 0 extended map.
    logic [7:0] hfa_prog_q; // Threshold, clock disable and pin bits.
    logic [7:0] vw_dac_q; // Video window count and reference power.
    logic [7:0] host_stop_q; // Host cycle stop controls.
    logic [7:0] rdata_q; // Read data holding register.
    status_t status_q; // Registered block outputs.
    status_t status_d; // Next block outputs.
    logic blink_prev_q; // Last sample of the text cursor blink.
    logic blink_half_q; // Blink phase at half the cursor rate.

    // ------------------------------------------------------------------
    // Port decoding
    // ------------------------------------------------------------------
    logic wr_index; // Write to the index port.
    logic wr_data; // Write to the data port.
    logic rd_data; // Read from the data port.
    logic hit_icon3; // Data write to the icon 3 register.
    logic hit_cursor; // Data write to the cursor register.
    logic hit_hfa_prog; // Data write to the threshold register.
    logic hit_vw_dac; // Data write to the video window register.
    logic hit_host_stop; // Data write to the host stop register.
    logic [7:0] rd_val; // Selected register for a data read.

    // Index and data strobes come straight from the host port.
    assign wr_index = IO_REQ_I.wr && !IO_REQ_I.data_sel;
    assign wr_data = IO_REQ_I.wr && IO_REQ_I.data_sel;
    assign rd_data = IO_REQ_I.rd && IO_REQ_I.data_sel;

    // Each write hit is the data strobe qualified by the held index.
    assign hit_icon3 = wr_data && (index_q == IDX_ICON3);
    assign hit_cursor = wr_data && (index_q == IDX_CURSOR);
    assign hit_hfa_prog = wr_data && (index_q == IDX_HFA_PROG);
    assign hit_vw_dac = wr_data && (index_q == IDX_VW_DAC);
    assign hit_host_stop = wr_data && (index_q == IDX_HOST_STOP);

    // ------------------------------------------------------------------
    // Cursor fine position control
    // ------------------------------------------------------------------
    logic fine_wr_ok; // The cursor, not the icon, is selected.
    logic fine_forced; // Graphics mode without horizontal expansion.
    logic [7:0] cursor_wr; // Masked value a cursor write would store.
    logic [7:0] cursor_d; // Next cursor register value.

    // Fine bit updates only while the cursor is the selected object.
    assign fine_wr_ok = !CTX_I.cursor_icon_sel; // [RULE_13]
    assign fine_forced = CTX_I.graphics_mode && !CTX_I.horiz_expand;

    // Keep the old fine bit when the icon owns the position registers.
    assign cursor_wr = {IO_REQ_I.wdata[7:1] & MASK_CURSOR[7:1],
                        fine_wr_ok ? IO_REQ_I.wdata[B_FINE3] : cursor_q[B_FINE3]};

    // The forced zero also clears the stored bit so it reads as zero.
    always_comb begin
        cursor_d = hit_cursor ? cursor_wr : cursor_q;
        if (fine_forced) begin
            cursor_d[B_FINE3] = 1'b0; // [RULE_14]
        end
    end

    // ------------------------------------------------------------------
    // Read multiplexer
    // ------------------------------------------------------------------
    // Unknown and spare indices read as zero.
    always_comb begin
        if (index_q == IDX_ICON3) begin
            rd_val = icon3_q;
        end else if (index_q == IDX_CURSOR) begin
            rd_val = cursor_q;
        end else if (index_q == IDX_HFA_PROG) begin
            rd_val = hfa_prog_q;
        end else if (index_q == IDX_VW_DAC) begin
            rd_val = vw_dac_q;
        end else if (index_q == IDX_HOST_STOP) begin
            rd_val = host_stop_q;
        end else begin
            rd_val = RST_VAL; // [RULE_23]
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    // Index register; any value is accepted and held.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            index_q <= RST_VAL;
        end else if (wr_index) begin
            index_q <= IO_REQ_I.wdata;
        end
    end

    // Icon 3 register; every bit is writable.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            icon3_q <= RST_VAL;
        end else if (hit_icon3) begin
            icon3_q <= IO_REQ_I.wdata & MASK_ICON3;
        end
    end

    // Cursor register; reserved bits are masked off on the way in.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            cursor_q <= RST_VAL;
        end else begin
            cursor_q <= cursor_d; // [RULE_13] [RULE_23]
        end
    end

    // Threshold and pin register.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            hfa_prog_q <= RST_VAL;
        end else if (hit_hfa_prog) begin
            hfa_prog_q <= IO_REQ_I.wdata & MASK_HFA_PROG;
        end
    end

    // Video window count and reference power; reserved bits stay zero.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            vw_dac_q <= RST_VAL;
        end else if (hit_vw_dac) begin
            vw_dac_q <= IO_REQ_I.wdata & MASK_VW_DAC; // [RULE_23]
        end
    end

    // Host stop controls; their effect lives in the memory arbiter.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            host_stop_q <= RST_VAL;
        end else if (hit_host_stop) begin
            host_stop_q <= IO_REQ_I.wdata & MASK_HOST_STOP; // [RULE_23]
        end
    end

    // Read data: the index port returns the index, the data port the register.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            rdata_q <= RST_VAL;
        end else if (IO_REQ_I.rd) begin
            rdata_q <= IO_REQ_I.data_sel ? rd_val : index_q;
        end
    end

    // ------------------------------------------------------------------
    // Icon blink divider
    // ------------------------------------------------------------------
    logic blink_rise; // Rising edge of the cursor blink phase.

    // Toggling on each rising edge halves the cursor blink rate.
    assign blink_rise = CTX_I.text_blink && !blink_prev_q;

    // Blink edge detector and half-rate phase.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            blink_prev_q <= 1'b0;
            blink_half_q <= 1'b0;
        end else begin
            blink_prev_q <= CTX_I.text_blink;
            blink_half_q <= blink_half_q ^ blink_rise; // [RULE_07]
        end
    end

    // ------------------------------------------------------------------
    // Output decoding
    // ------------------------------------------------------------------
    logic [1:0] ext_map; // Icon 0 extended map field.
    logic ext_map_on; // Extended map mode is active.

    assign ext_map = cursor_q[B_EXTMAP +: 2];
    assign ext_map_on = (ext_map != 2'b00);

    // All status outputs are decoded here and registered in status_q.
    always_comb begin
        status_d = '0;
        // Host width is narrowed only under linear addressing.
        status_d.icon_host_64 = !CTX_I.linear_addr || icon3_q[B_WIDE]; // [RULE_01]
        // Narrow-read clear fixes 64-bit fetch; set follows the mode.
        status_d.icon_fetch_64 = !icon3_q[B_NARROW] || CTX_I.ext_mode
                                 || icon3_q[B_WIDE]; // [RULE_03]
        status_d.icon3_map_sel = icon3_q[B_I3_MAP]; // [RULE_04]
        status_d.icon3_vdouble = icon3_q[B_I3_VDBL]; // [RULE_05]
        status_d.icons_pushed_down = icon3_q[B_I3_VDBL] && icon3_q[B_I3_EN]; // [RULE_05]
        status_d.icon3_hdouble = icon3_q[B_I3_HDBL]; // [RULE_06]
        status_d.icon3_transparent = icon3_q[B_I3_MODE]; // [RULE_08]
        // Blink blanks the icon on alternate half-rate phases.
        status_d.icon3_visible = icon3_q[B_I3_EN] && !ext_map_on
                                 && (!icon3_q[B_I3_BLINK] || blink_half_q); // [RULE_07] [RULE_09]
        // Extended map mode leaves only icon 0 usable.
        status_d.icons_1_3_allowed = !ext_map_on; // [RULE_10]
        // Extended field forms the upper bits of icon 0's map index.
        status_d.icon0_map_index = {ext_map, CTX_I.icon0_map_sel}; // [RULE_11]
        // Coarse, fine bit three and low fine bits form twelve bits.
        status_d.cursor_hpos = {CTX_I.coarse_hpos, cursor_q[B_FINE3],
                                CTX_I.fine_hpos_low}; // [RULE_12]
        // Pins follow their bits unless TV output takes two of them.
        status_d.prog_pins = hfa_prog_q[B_PROG +: 3]; // [RULE_16]
        if (CTX_I.tv_out_sel) begin
            status_d.prog_pins[PROG_NTSC] = CTX_I.ntsc_pal; // [RULE_17]
            status_d.prog_pins[PROG_TVON] = CTX_I.tv_power_on_output; // [RULE_17]
        end
        // Pixel clock is gated off in CRT-only use when disabled.
        status_d.pclk_out_en = CTX_I.pclk_sel && (!hfa_prog_q[B_PCLK_DIS]
                               || CTX_I.flat_panel_en); // [RULE_18]
        status_d.dac_dac_current_reference_on = vw_dac_q[B_DAC_CURRENT_REFERENCE]; // [RULE_21]
        status_d.hfa_vw_cas = vw_dac_q[B_VWCAS +: 3]; // [RULE_22]
        status_d.host_stop = host_stop_q[B_STOP +: 5];
    end

    // Output register.
    always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
        if (!RESETN_I) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign STATUS_O = status_q;
    assign IO_RDATA_O = rdata_q;

    // ------------------------------------------------------------------
    // Half-frame FIFO request
    // ------------------------------------------------------------------
    // The tracker's own flop drives the request output.
    hfa_fifo_tracker u_hfa_tracker (
        .clk_i(CLK_SYS_I),
        .rst_n_i(RESETN_I),
        .thr_i(hfa_prog_q[B_THR +: 4]),
        .drain_i(HFA_DRAIN_I),
        .fill_i(HFA_FILL_I),
        .fill_req_o(HFA_FILL_REQ_O),
        .empty_o()
    );

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    host_width_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_01]
        CTX_I.linear_addr && !icon3_q[B_WIDE] |=> !STATUS_O.icon_host_64)
        else $error("Host width not narrowed.");

    fetch_width_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_03]
        !icon3_q[B_NARROW] |=> STATUS_O.icon_fetch_64)
        else $error("Fetch width not 64 bits.");

    icon3_map_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_04]
        hit_icon3 |=> ##1 STATUS_O.icon3_map_sel == $past(IO_REQ_I.wdata[B_I3_MAP], 2))
        else $error("Icon 3 map select wrong.");

    icon3_off_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_09]
        !icon3_q[B_I3_EN] |=> !STATUS_O.icon3_visible)
        else $error("Disabled icon 3 shown.");

    ext_map_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_10]
        ext_map_on |=> !STATUS_O.icons_1_3_allowed && !STATUS_O.icon3_visible)
        else $error("Icons allowed in extended map mode.");

    map_index_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_11]
        1'b1 |=> STATUS_O.icon0_map_index == $past({ext_map, CTX_I.icon0_map_sel}))
        else $error("Icon 0 map index wrong.");

    fine_lock_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_13]
        hit_cursor && CTX_I.cursor_icon_sel && !fine_forced |=> $stable(cursor_q[B_FINE3]))
        else $error("Fine bit written while icon selected.");

    fine_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_14]
        fine_forced |=> !cursor_q[B_FINE3] ##1 !STATUS_O.cursor_hpos[3])
        else $error("Fine bit not forced to zero.");

    prog_pins_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_16]
        !CTX_I.tv_out_sel |=> STATUS_O.prog_pins == $past(hfa_prog_q[B_PROG +: 3]))
        else $error("Pins do not follow register.");

    tv_pins_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_17]
        CTX_I.tv_out_sel |=> STATUS_O.prog_pins[PROG_NTSC] == $past(CTX_I.ntsc_pal)
        && STATUS_O.prog_pins[PROG_TVON] == $past(CTX_I.tv_power_on_output)
        && STATUS_O.prog_pins[1] == $past(hfa_prog_q[B_PROG + 1]))
        else $error("TV pin routing wrong.");

    pclk_gate_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_18]
        hfa_prog_q[B_PCLK_DIS] && !CTX_I.flat_panel_en |=> !STATUS_O.pclk_out_en)
        else $error("Pixel clock not gated.");

    dac_current_reference_power_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_21]
        hit_vw_dac |=> ##1 STATUS_O.dac_dac_current_reference_on == $past(IO_REQ_I.wdata[B_DAC_CURRENT_REFERENCE], 2))
        else $error("Reference power wrong.");

    vw_cas_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_22]
        hit_vw_dac |=> ##1 STATUS_O.hfa_vw_cas == $past(IO_REQ_I.wdata[2:0], 2))
        else $error("Column strobe count wrong.");

    spare_zero_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_23]
        rd_data && index_q == IDX_SPARE |=> IO_RDATA_O == 8'h00)
        else $error("Spare register not zero.");

    blink_half_a: assert property (@(posedge CLK_SYS_I) disable iff (!RESETN_I) // [RULE_07]
        blink_rise |=> blink_half_q != $past(blink_half_q))
        else $error("Blink phase did not toggle.");

    // Main scenarios worth seeing.
    tv_mode_c: cover property (@(posedge CLK_SYS_I) CTX_I.tv_out_sel && hit_hfa_prog);
    ext_map_c: cover property (@(posedge CLK_SYS_I) ext_map_on && STATUS_O.icon0_map_index[2]);
    fine_lock_c: cover property (@(posedge CLK_SYS_I) hit_cursor && CTX_I.cursor_icon_sel);
    fill_req_c: cover property (@(posedge CLK_SYS_I) $rose(HFA_FILL_REQ_O));
endmodule

// >>> sim/icon_cursor_hfa_seq_regs_tb.sv
// Self-checking bench for the sequencer extension register bank.
// Assumes seq_ext_pkg and the design files are compiled before this one.
`timescale 1ns/100ps
module icon_cursor_hfa_seq_regs_tb;
import seq_ext_pkg::*;
// --------------------------------------------------------------------
// Stimulus, model state and counters
// --------------------------------------------------------------------
logic clk = 1'b0, rst_n = 1'b0, drain = 1'b0, fill = 1'b0, fill_req, old;
io_req_t req = '0;
ctx_t ctx = '0;
status_t st;
logic [7:0] rdata, got, v;
logic [7:0] m[7] = '{default: 8'h00};
logic [7:0] idx[7] = '{IDX_ICON3, IDX_CURSOR, IDX_HFA_PROG, IDX_VW_DAC, IDX_SPARE,
    IDX_HOST_STOP, 8'h40};
logic [7:0] msk[7] = '{8'hFF, 8'h07, 8'hFF, 8'h27, 8'h00, 8'h1F, 8'h00};
int err_count = 0, samples_checked = 0, seed = 90, empty = 16, i, k;
always #4 clk = ~clk;
icon_cursor_hfa_seq_regs icon_cursor_hfa_seq_regs_i (.CLK_SYS_I(clk), .RESETN_I(rst_n),
    .IO_REQ_I(req), .IO_RDATA_O(rdata), .CTX_I(ctx), .HFA_DRAIN_I(drain),
    .HFA_FILL_I(fill), .STATUS_O(st), .HFA_FILL_REQ_O(fill_req));
// --------------------------------------------------------------------
// Shared tasks: compare, clock step, register access, verdict
// --------------------------------------------------------------------
task automatic chk(input logic [11:0] g, input logic [11:0] e);
    samples_checked++;
    if (g !== e) begin
        $display("wrong value at %0t: got %h expected %h", $time, g, e);
        err_count++;
    end
endtask
task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{1'b0, 1'b1, 1'b0, a};
    cyc(1);
    req = '{1'b1, 1'b1, 1'b0, d};
    cyc(1);
    req = '0;
    cyc(2);
endtask
task automatic rd(input logic [7:0] a);
    req = '{1'b0, 1'b1, 1'b0, a};
    cyc(1);
    req = '{1'b1, 1'b0, 1'b1, 8'h00};
    cyc(1);
    req = '0;
    got = rdata;
    cyc(1);
endtask
task automatic st_chk;
    chk(st.icon_host_64, m[0][7]);
    chk(st.icon_fetch_64, !m[0][6] | ctx.ext_mode | m[0][7]);
    chk({st.icon3_map_sel, st.icon3_vdouble, st.icon3_hdouble}, m[0][5:3]);
    chk({st.icon3_transparent, st.icons_pushed_down}, {m[0][1], m[0][4] & m[0][0]});
    chk(st.icon3_visible, m[0][0] & (m[1][2:1] == 2'b00));
    chk({st.icons_1_3_allowed, st.icon0_map_index}, {m[1][2:1] == 2'b00, m[1][2:1], ctx.icon0_map_sel});
    chk(st.cursor_hpos, {ctx.coarse_hpos, m[1][0], ctx.fine_hpos_low});
    chk(st.prog_pins, ctx.tv_out_sel ? {ctx.ntsc_pal, m[2][6], ctx.tv_power_on_output} : m[2][7:5]);
    chk(st.pclk_out_en, !m[2][4] | ctx.flat_panel_en);
    chk({st.dac_dac_current_reference_on, st.hfa_vw_cas, st.host_stop}, {m[3][5], m[3][2:0], m[5][4:0]});
endtask
task automatic stop_test;
    if (err_count == 0 && samples_checked > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask
// Watchdog: the whole sequence needs well under 2000 cycles.
initial begin
    #100000;
    err_count++;
    stop_test();
end
// --------------------------------------------------------------------
// Main sequence: reset values, random writes, blink, FIFO walk
// --------------------------------------------------------------------
initial begin
    cyc(6);
    rst_n = 1'b1;
    for (k = 0; k < 6; k++) begin
        rd(idx[k]);
        chk(got, 8'h00);
    end
    for (i = 0; i < 56; i++) begin
        k = i % 7;
        ctx = 23'($random(seed));
        ctx.linear_addr = 1'b1;
        ctx.text_blink = 1'b0;
        ctx.pclk_sel = 1'b1;
        ctx.coarse_hpos = ctx.horiz_expand ? 8'h00 : ctx.coarse_hpos;
        v = 8'($random(seed));
        v[2] = (k == 0) ? 1'b0 : v[2];
        v[6] = (k == 0 && !v[7]) ? 1'b1 : v[6];
        v[3:0] = (k == 2 && v[3:0] < 4'h4) ? 4'h4 : v[3:0];
        old = m[1][0];
        wr(idx[k], v);
        m[k] = v & msk[k];
        m[1][0] = ctx.cursor_icon_sel ? old : m[1][0];
        m[1][0] = (ctx.graphics_mode & ~ctx.horiz_expand) ? 1'b0 : m[1][0];
        st_chk();
        chk(fill_req, 1'b1);
        rd(idx[k]);
        chk(got, m[k]);
    end
    // Blink phase must flip on each rise of the text blink level.
    wr(IDX_CURSOR, 8'h00);
    wr(IDX_ICON3, 8'h05);
    chk(st.icon3_visible, 1'b0);
    for (i = 0; i < 2; i++) begin
        ctx.text_blink = 1'b1;
        cyc(3);
        ctx.text_blink = 1'b0;
        cyc(3);
        chk(st.icon3_visible, i == 0);
    end
    // Eight of ten fills empty the count to zero, then a random walk of pulses.
    wr(IDX_HFA_PROG, 8'h06);
    for (i = 0; i < 80; i++) begin
        v = 8'($random(seed));
        drain = (i >= 10) & v[0];
        fill = (i < 10) | v[1];
        cyc(1);
        // Both refusals are judged on the count before this edge.
        k = empty;
        empty = (fill && k >= 2) ? empty - 2 : empty;
        empty = (drain && k < 16) ? empty + 1 : empty;
        drain = 1'b0;
        fill = 1'b0;
        cyc(1);
        chk(fill_req, empty >= 6);
    end
    stop_test();
end
endmodule
